// File: hw/lrsf_lane_flags.sv
// Per-lane one-cycle error flag registers
`default_nettype none
module lrsf_lane_flags
(
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   // Raw events
   input wire logic [lrsf_pkg::NUM_LANES-1:0] scram_ev_in,
   input wire logic [lrsf_pkg::NUM_LANES-1:0] sync_ev_in,
   input wire logic [lrsf_pkg::NUM_LANES-1:0] frame_ev_in,
   // Registered flags
   output lrsf_pkg::lrsf_lane_err_type flags_out
);
   lrsf_pkg::lrsf_lane_err_type state_r;
   lrsf_pkg::lrsf_lane_err_type state_nxt;

   // One generate lane per bit; each flag follows its raw event, registered one cycle later
   for (genvar i = 0; i < lrsf_pkg::NUM_LANES; i++)
   begin : g_lane
      always_comb
      begin
         state_nxt.lane_scrambler_state_mismatch[i] = scram_ev_in[i];
         state_nxt.lane_sync_word_malformed[i] = sync_ev_in[i];
         state_nxt.lane_framing_error[i] = frame_ev_in[i];
      end
   end

   // Register in the local clock domain
   always_ff @(posedge core_clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         state_r <= '0;
      end
      else
      begin
         state_r <= state_nxt;
      end
   end

   assign flags_out = state_r;
endmodule // lrsf_lane_flags
`default_nettype wire

// File: hw/lrsf_pkg.sv
// Package with constants and carrier types for the lane receive status flag block
`default_nettype none
package lrsf_pkg;
   localparam int NUM_LANES = 12;
   localparam int CRC_WIDTH = 24;
   localparam logic [NUM_LANES-1:0] LANES_RESET = 12'h000;
   localparam logic [NUM_LANES-1:0] LANES_ALL = 12'hfff;

   // Per-lane raw detector events from the lane logic
   typedef struct packed {
      logic [NUM_LANES-1:0] scram_mismatch;
      logic [NUM_LANES-1:0] sync_word_bad;
      logic [NUM_LANES-1:0] framing_bad;
      logic [NUM_LANES-1:0] sync_word_seen;
      logic [NUM_LANES-1:0] lane_locked;
      logic [NUM_LANES-1:0] lane_active;
   } lrsf_lane_ev_type;

   // Per-lane error flags to the user
   typedef struct packed {
      logic [NUM_LANES-1:0] lane_scrambler_state_mismatch;
      logic [NUM_LANES-1:0] lane_sync_word_malformed;
      logic [NUM_LANES-1:0] lane_framing_error;
   } lrsf_lane_err_type;

   // Link-wide status to the user
   typedef struct packed {
      logic aligned;
      logic alignment_lost;
      logic control_word_check_error;
      logic fifo_overflow;
      logic missing_packet_start;
      logic missing_packet_end;
      logic burst_error;
      logic cross_lane_sync_missing;
   } lrsf_link_stat_type;

   // Packet framing state for start/end repair
   typedef enum logic [1:0] {
      LRSF_IDLE,
      LRSF_IN_PKT
   } lrsf_pkt_state_type;
endpackage : lrsf_pkg
`default_nettype wire

// File: hw/lrsf_top.sv
// Top of the lane receive status flag block
`default_nettype none
module lrsf_top
(
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   // Per-lane detector events
   input wire lrsf_pkg::lrsf_lane_ev_type lane_ev_in,
   // Control word CRC check
   input wire logic ctl_word_valid_in,
   input wire logic [lrsf_pkg::CRC_WIDTH-1:0] ctl_crc_calc_in,
   input wire logic [lrsf_pkg::CRC_WIDTH-1:0] ctl_crc_rx_in,
   // Packet framing from the receive stream
   input wire logic word_valid_in,
   input wire logic sop_in,
   input wire logic eop_in,
   // Burst and FIFO events
   input wire logic burst_short_in,
   input wire logic burst_len_bad_in,
   input wire logic fifo_write_in,
   input wire logic fifo_full_in,
   // Corrected framing markers
   output var logic sop_fixed_out,
   output var logic eop_fixed_out,
   // Status outputs
   output lrsf_pkg::lrsf_lane_err_type lane_err_out,
   output lrsf_pkg::lrsf_link_stat_type link_stat_out
);
   typedef struct packed {
      lrsf_pkg::lrsf_link_stat_type stat;
      lrsf_pkg::lrsf_pkt_state_type pkt;
      logic [lrsf_pkg::NUM_LANES-1:0] seen;
      logic first_sync_done;
      logic sop_fix;
      logic eop_fix;
   } lrsf_top_state_type;

   lrsf_top_state_type state_r;
   lrsf_top_state_type state_nxt;
   logic all_locked;
   logic any_seen;
   logic [lrsf_pkg::NUM_LANES-1:0] act_seen;

   // Per-lane flags
   lrsf_lane_flags u_lane_flags
   (
      .core_clk_in(core_clk_in),
      .sys_rst_in(sys_rst_in),
      .scram_ev_in(lane_ev_in.scram_mismatch),
      .sync_ev_in(lane_ev_in.sync_word_bad),
      .frame_ev_in(lane_ev_in.framing_bad),
      .flags_out(lane_err_out)
   );

   // Lane combination terms
   assign all_locked = (lane_ev_in.lane_locked == lrsf_pkg::LANES_ALL);
   assign act_seen = lane_ev_in.sync_word_seen & lane_ev_in.lane_active;
   assign any_seen = |act_seen;

   // Next-state logic
   always_comb
   begin
      state_nxt = state_r;
      state_nxt.stat.alignment_lost = 1'b0;
      state_nxt.stat.control_word_check_error = 1'b0;
      state_nxt.stat.fifo_overflow = 1'b0;
      state_nxt.stat.missing_packet_start = 1'b0;
      state_nxt.stat.missing_packet_end = 1'b0;
      state_nxt.stat.burst_error = 1'b0;
      state_nxt.stat.cross_lane_sync_missing = 1'b0;
      state_nxt.sop_fix = 1'b0;
      state_nxt.eop_fix = 1'b0;
      state_nxt.seen = state_r.seen | lane_ev_in.sync_word_seen;
      if ((state_r.seen | lane_ev_in.sync_word_seen) == lrsf_pkg::LANES_ALL)
      begin
         state_nxt.first_sync_done = 1'b1;
      end
      // Aligned is a held level
      state_nxt.stat.aligned = all_locked;
      // Aligner error or drop of achieved alignment
      if ((state_r.stat.aligned && !all_locked) ||
          (!all_locked && (|lane_ev_in.sync_word_bad)))
      begin
         state_nxt.stat.alignment_lost = 1'b1;
      end
      if (ctl_word_valid_in && (ctl_crc_calc_in != ctl_crc_rx_in))
      begin
         state_nxt.stat.control_word_check_error = 1'b1;
      end
      // Write into a full FIFO means the drain clock is too slow
      state_nxt.stat.fifo_overflow = fifo_write_in & fifo_full_in;
      state_nxt.stat.burst_error = burst_short_in | burst_len_bad_in;
      // Sync word on some but not all active lanes together
      if (state_r.first_sync_done && any_seen && (act_seen != lane_ev_in.lane_active))
      begin
         state_nxt.stat.cross_lane_sync_missing = 1'b1;
      end
      // Packet framing repair
      if (word_valid_in)
      begin
         case (state_r.pkt)
            lrsf_pkg::LRSF_IDLE:
            begin
               if (!sop_in)
               begin
                  state_nxt.stat.missing_packet_start = 1'b1;
                  state_nxt.sop_fix = 1'b1;
               end
               if (!eop_in)
               begin
                  state_nxt.pkt = lrsf_pkg::LRSF_IN_PKT;
               end
            end
            lrsf_pkg::LRSF_IN_PKT:
            begin
               if (sop_in)
               begin
                  state_nxt.stat.missing_packet_end = 1'b1;
                  state_nxt.eop_fix = 1'b1;
               end
               if (eop_in)
               begin
                  state_nxt.pkt = lrsf_pkg::LRSF_IDLE;
               end
            end
            default:
            begin
               state_nxt.pkt = lrsf_pkg::LRSF_IDLE;
            end
         endcase
      end
   end

   // State register
   always_ff @(posedge core_clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         state_r <= '0;
         state_r.seen <= lrsf_pkg::LANES_RESET;
         state_r.pkt <= lrsf_pkg::LRSF_IDLE;
      end
      else
      begin
         state_r <= state_nxt;
      end
   end

   assign link_stat_out = state_r.stat;
   assign sop_fixed_out = state_r.sop_fix;
   assign eop_fixed_out = state_r.eop_fix;
endmodule // lrsf_top
`default_nettype wire

// File: verification/lrsf_far_tx.sv
// Far-end transmitter model producing per-lane receive events
`default_nettype none
module lrsf_far_tx
(
   // Commands
   input wire logic [11:0] lock_in,
   input wire logic [11:0] sync_in,
   input wire logic [35:0] err_in,
   // Lane events
   output lrsf_pkg::lrsf_lane_ev_type ev_out
);
   timeunit 1ns;
   timeprecision 1ns;
   // Every lane active; errors, sync and lock as commanded
   always_comb
   begin
      ev_out = {err_in, sync_in, lock_in, lrsf_pkg::LANES_ALL};
   end
endmodule // lrsf_far_tx
`default_nettype wire

// File: verification/lrsf_top_properties.sv
// Port checker for the lane receive status flag block
`default_nettype none
module lrsf_top_chk
(
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   // Watched inputs
   input wire lrsf_pkg::lrsf_lane_ev_type lane_ev_in,
   input wire logic ctl_word_valid_in,
   input wire logic word_valid_in,
   input wire logic sop_in,
   input wire logic [lrsf_pkg::CRC_WIDTH-1:0] ctl_crc_calc_in,
   input wire logic [lrsf_pkg::CRC_WIDTH-1:0] ctl_crc_rx_in,
   input wire logic burst_short_in,
   input wire logic burst_len_bad_in,
   input wire logic fifo_write_in,
   input wire logic fifo_full_in,
   // Watched outputs
   input wire logic sop_fixed_out,
   input wire logic eop_fixed_out,
   input wire lrsf_pkg::lrsf_lane_err_type lane_err_out,
   input wire lrsf_pkg::lrsf_link_stat_type link_stat_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [lrsf_pkg::NUM_LANES-1:0] seen_r;
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (sys_rst_in);
   // Lanes that have shown the sync word so far
   always_ff @(posedge core_clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in) seen_r <= lrsf_pkg::LANES_RESET;
      else seen_r <= seen_r | lane_ev_in.sync_word_seen;
   end
   AST_SCRAM: assert property (##1 lane_err_out.lane_scrambler_state_mismatch
      == $past(lane_ev_in.scram_mismatch)) else $error("scrambler flag wrong");
   AST_ALIGNED: assert property (##1 link_stat_out.aligned == $past(&lane_ev_in.lane_locked))
      else $error("aligned level wrong");
   AST_LOST: assert property ($fell(link_stat_out.aligned) |-> link_stat_out.alignment_lost)
      else $error("alignment loss not flagged");
   AST_CRC: assert property (ctl_word_valid_in && ctl_crc_calc_in != ctl_crc_rx_in |=>
      link_stat_out.control_word_check_error) else $error("check error missed");
   AST_OVERFLOW: assert property (##1 link_stat_out.fifo_overflow == $past(fifo_write_in && fifo_full_in))
      else $error("overflow flag wrong");
   AST_START: assert property (link_stat_out.missing_packet_start |-> sop_fixed_out && $past(word_valid_in && !sop_in))
      else $error("start repair and flag differ");
   AST_END: assert property (link_stat_out.missing_packet_end |-> eop_fixed_out && $past(word_valid_in && sop_in))
      else $error("end repair and flag differ");
   AST_BURST: assert property (!(burst_short_in || burst_len_bad_in) |=> !link_stat_out.burst_error)
      else $error("burst flag without cause");
   AST_MISAL: assert property (link_stat_out.cross_lane_sync_missing |-> &seen_r)
      else $error("misalignment before full sync");
endmodule // lrsf_top_chk
bind lrsf_top lrsf_top_chk u_chk (.core_clk_in, .sys_rst_in, .lane_ev_in, .ctl_word_valid_in, .ctl_crc_calc_in,
   .ctl_crc_rx_in, .burst_short_in, .burst_len_bad_in, .fifo_write_in, .fifo_full_in, .sop_fixed_out, .lane_err_out,
   .link_stat_out, .word_valid_in, .sop_in, .eop_fixed_out);
`default_nettype wire

// File: verification/tb_lrsf_top.sv
// Self-checking bench for the lane receive status flag block
`default_nettype none
module tb_lrsf_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic [11:0] lock = 12'h000, sync = 12'h000, seen = 12'h000;
   logic [35:0] err = 36'h0;
   logic [23:0] calc = 24'h0, rx = 24'h0;
   logic cv = 1'b0, wv = 1'b0, sop = 1'b0, eop = 1'b0, bs = 1'b0, bl = 1'b0, fw = 1'b0, ff = 1'b0;
   logic sfix, efix, inp = 1'b0, wal = 1'b0;
   logic [31:0] r, q = 32'he3c5;
   logic [45:0] e;
   logic [45:0] notes[$];
   lrsf_pkg::lrsf_lane_ev_type ev;
   lrsf_pkg::lrsf_lane_err_type lerr;
   lrsf_pkg::lrsf_link_stat_type lst;
   int err_total = 0, checks = 0, cyc = 0;
   always #5 core_clk_in = ~core_clk_in;
   lrsf_far_tx u_far (.lock_in(lock), .sync_in(sync), .err_in(err), .ev_out(ev));
   lrsf_top u_dut (.core_clk_in, .sys_rst_in, .lane_ev_in(ev), .ctl_word_valid_in(cv), .ctl_crc_calc_in(calc),
      .ctl_crc_rx_in(rx), .word_valid_in(wv), .sop_in(sop), .eop_in(eop), .burst_short_in(bs), .burst_len_bad_in(bl),
      .fifo_write_in(fw), .fifo_full_in(ff), .sop_fixed_out(sfix), .eop_fixed_out(efix), .lane_err_out(lerr),
      .link_stat_out(lst));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      for (int k = 0; k < 32; k++) s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
      return s;
   endfunction
   task automatic chk(input logic [45:0] seen_v, input logic [45:0] exp_v);
      checks++;
      if (seen_v !== exp_v)
      begin
         err_total++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen_v, exp_v);
      end
   endtask
   task automatic give_verdict;
      $display("mismatches %0d comparisons %0d", err_total, checks);
      if (err_total == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // Compare outputs with the oldest note; cut a hang short
   always @(negedge core_clk_in)
   begin
      cyc++;
      if (notes.size() > 0)
         chk({sfix, efix, lerr, lst}, notes.pop_front());
      if (cyc == 1500)
      begin
         err_total++;
         give_verdict();
      end
   end
   // Note what the sampled inputs must give, then drive new ones
   initial
   begin
      repeat (5) @(posedge core_clk_in);
      sys_rst_in <= 1'b0;
      for (int i = 0; i < 400; i++)
      begin
         @(posedge core_clk_in);
         e[45] = wv & ~sop & ~inp;
         e[44] = wv & sop & inp;
         e[43:8] = err;
         e[7] = &lock;
         e[6] = (wal | (|err[23:12])) & ~(&lock);
         e[5] = cv & (calc != rx);
         e[4] = fw & ff;
         e[3:2] = e[45:44];
         e[1] = bs | bl;
         e[0] = (&seen) & (sync != 12'h000) & (sync != 12'hfff);
         notes.push_back(e);
         wal = &lock;
         seen = seen | sync;
         if (wv) inp = ~eop;
         r = lfsr(q);
         q = lfsr(r);
         lock <= (i < 40 || r[4:0] != 5'h00) ? 12'hfff : q[11:0];
         sync <= i < 20 ? 12'h0f0 : i < 22 ? 12'hfff : r[7:5] == 3'h0 ? q[23:12] : {12{r[8]}};
         err <= r[31:29] == 3'h0 ? {q[31:20], r[27:16], q[11:0]} : 36'h0;
         calc <= q[23:0];
         rx <= r[9] ? q[23:0] : r[23:0];
         {cv, wv, sop, eop, bs, bl, fw, ff} <= r[17:10];
      end
      @(posedge core_clk_in);
      give_verdict();
   end
endmodule // tb_lrsf_top
`default_nettype wire
